// [bench/lsi0d_assertions.sv]
// port checker for the slave image 0 decode top
// assumes one clock; bound to lsi0d_top after the module
`timescale 1ns/10ps
`default_nettype none
module lsi0d_assertions
    import lsi0d_pkg::*;
(
    // clock and reset
    input wire logic          ref_clk,
    input wire logic          arst_n,
    // register bus
    input wire logic          avs_read,
    input wire logic          avs_write,
    input wire logic          avs_waitrequest,
    // local access
    input wire logic          bridge_chip_select_n,
    input wire logic          image_select,
    input wire logic          access_write,
    input wire logic          access_burst,
    input wire logic [31:0]   access_addr,
    // decode outputs
    input wire logic          decode_valid,
    input wire lsi0d_action_t decode_action,
    input wire logic          decode_io_space,
    input wire logic [31:0]   decode_pci_addr,
    input wire logic          bus_error
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    logic        hit;
    logic [15:0] low_q;
    assign hit = !bridge_chip_select_n && !image_select;
    always_ff @(posedge ref_clk) low_q <= access_addr[15:0];
    sequence s_ack;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    a_wait_once: assert property ($rose(avs_read || avs_write) |-> s_ack)
        else $error("waitrequest not one cycle");
    a_hit_valid: assert property (hit |=> decode_valid)
        else $error("hit not decoded");
    a_miss_idle: assert property (!hit |=> !decode_valid
        && decode_action == LSI0D_NONE && decode_pci_addr == 32'h0)
        else $error("miss decoded");
    a_err_flag: assert property (bus_error ==
        (decode_action == LSI0D_BUS_ERROR)) else $error("bus error flag");
    a_burst_io: assert property (hit && access_burst |=>
        decode_io_space == (decode_action == LSI0D_BUS_ERROR))
        else $error("io burst not refused");
    a_burst_mem: assert property (hit && access_burst ##1
        !decode_io_space |-> decode_action == ($past(access_write) ?
        LSI0D_POSTED_WRITE : LSI0D_DELAYED_READ)) else $error("mem burst");
    a_single_io: assert property (hit && !access_burst ##1
        decode_io_space |-> decode_action == ($past(access_write) ?
        LSI0D_DELAYED_WRITE : LSI0D_DELAYED_READ)) else $error("io single");
    a_low_lines: assert property (hit |=>
        decode_pci_addr[15:0] == low_q) else $error("low lines changed");
endmodule : lsi0d_assertions
bind lsi0d_top lsi0d_assertions chk (.*);
`default_nettype wire

// [bench/lsi0d_bench.sv]
// self-checking bench for the slave image 0 decode top
// assumes the local master model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module lsi0d_bench;
    import lsi0d_pkg::*;
    logic ref_clk = 1'b0, arst_n = 1'b0, eeprom_valid = 1'b0;
    logic eeprom_posted_write_enable = 1'b0, eeprom_pci_space_select = 1'b0;
    logic [15:0] eeprom_translation_address = 16'h0;
    logic [3:0] eeprom_block_size_code = 4'h0, avs_byteenable = 4'hf;
    logic eeprom_translation_enable = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [11:0] avs_address = 12'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, access_addr;
    logic [31:0] decode_pci_addr, rdata, m;
    logic avs_waitrequest, bridge_chip_select_n, image_select, access_write;
    logic access_burst, decode_valid, decode_io_space, bus_error;
    lsi0d_action_t decode_action, e;
    int n_errors = 0, total_checks = 0, k;
    lsi0d_top dut (.*);
    lsi0d_local_master master (.*);
    initial forever #5 ref_clk = ~ref_clk;
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 20) begin
            n_errors++;
            test_done();
        end
    endtask : bus
    function automatic lsi0d_action_t want(input logic pw, sp, pr, w, b);
        if (b && sp) return LSI0D_BUS_ERROR;
        if (w) return (b || (pw && !sp)) ? LSI0D_POSTED_WRITE
                                         : LSI0D_DELAYED_WRITE;
        return (!b && pr && !sp) ? LSI0D_DELAYED_PREFETCH_READ
                                 : LSI0D_DELAYED_READ;
    endfunction : want
    task automatic boot();
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        // first safe request comes at the fourth edge
        repeat (4) @(posedge ref_clk);
    endtask : boot
    initial begin
        boot();
        bus(0, 12'hf00, 0);
        chk(rdata, 32'h0);
        bus(0, 12'hf04, 0);
        chk(rdata, 32'h0);
        bus(1, 12'hf00, 32'hffffffff);
        bus(0, 12'hf00, 0);
        chk(rdata, 32'h81800000);
        bus(1, 12'h800, 32'hffffffff);
        bus(0, 12'h800, 0);
        chk(rdata, 32'h0);
        for (k = 0; k < 32; k++) begin
            bus(1, 12'hf00, {k[4], 6'h0, k[3], k[2], 23'h0});
            master.issue(1'b0, k[1], k[0], 32'h00001230);
            e = want(k[4], k[3], k[2], k[1], k[0]);
            chk(32'(decode_action), 32'(e));
            chk({decode_valid, decode_io_space, bus_error},
                {1'b1, k[3], e == LSI0D_BUS_ERROR});
        end
        bus(1, 12'hf00, 32'h0);
        for (k = 0; k < 17; k++) begin
            bus(1, 12'hf04, {16'ha5c3, 8'h0, k[3:0], 3'h0, k < 16});
            master.issue(1'b0, 1'b0, 1'b0, 32'h5a5a1234);
            m = (k == 16) ? 32'h0 : 32'hffffffff << (16 + k[3:0]);
            chk(decode_pci_addr,
                (32'h5a5a1234 & ~m) | (32'ha5c30000 & m));
        end
        bus(1, 12'hf04, 32'hffffffff);
        bus(0, 12'hf04, 0);
        chk(rdata, 32'hffff00f1);
        master.issue(1'b1, 1'b0, 1'b0, 32'h5a5a1234);
        chk({31'h0, decode_valid}, 32'h0);
        chk(decode_pci_addr, 32'h0);
        bus(1, 12'hf00, 32'h00800000);
        eeprom_valid <= 1'b1;
        eeprom_posted_write_enable <= 1'b1;
        eeprom_pci_space_select <= 1'b1;
        eeprom_translation_address <= 16'h1234;
        eeprom_block_size_code <= 4'h3;
        eeprom_translation_enable <= 1'b1;
        arst_n <= 1'b0;
        boot();
        bus(0, 12'hf00, 0);
        chk(rdata, 32'h81000000);
        bus(0, 12'hf04, 0);
        chk(rdata, 32'h12340031);
        test_done();
    end
endmodule : lsi0d_bench
`default_nettype wire

// [bench/lsi0d_local_master.sv]
// local bus master model issuing image accesses
// assumes the bench calls issue only after reset is out
`timescale 1ns/10ps
`default_nettype none
module lsi0d_local_master (
    // clock
    input  wire logic        ref_clk,
    // local access
    output logic             bridge_chip_select_n = 1'b1,
    output logic             image_select = 1'b0,
    output logic             access_write = 1'b0,
    output logic             access_burst = 1'b0,
    output logic      [31:0] access_addr = 32'h0
);
    task automatic issue(input logic s, w, b, input logic [31:0] a);
        @(posedge ref_clk);
        bridge_chip_select_n <= 1'b0;
        image_select <= s;
        access_write <= w;
        access_burst <= b;
        access_addr <= a;
        @(posedge ref_clk);
        bridge_chip_select_n <= 1'b1;
        // released address lines show junk, not the last address; select, write and burst hold
        access_addr <= ~a;
        #1;
    endtask : issue
endmodule : lsi0d_local_master
`default_nettype wire

// [rtl/lsi0d_pkg.sv]
// types shared by the slave image 0 decode block
// assumes nothing beyond the register header
package lsi0d_pkg;
    typedef enum logic [2:0] {
        LSI0D_NONE,
        LSI0D_POSTED_WRITE,
        LSI0D_DELAYED_WRITE,
        LSI0D_DELAYED_READ,
        LSI0D_DELAYED_PREFETCH_READ,
        LSI0D_BUS_ERROR
    } lsi0d_action_t;
endpackage : lsi0d_pkg

// [rtl/lsi0d_regs.svh]
// register offsets, field positions, reset values for slave image 0 decode
// assumes inclusion from the package and the design modules only
`ifndef LSI0D_REGS_SVH
`define LSI0D_REGS_SVH
`define LSI0D_OFS_CONTROL      12'hf00
`define LSI0D_OFS_TRANSLATION  12'hf04
`define LSI0D_POS_POSTED_WRITE_ENABLE         31
`define LSI0D_POS_SPACE        24
`define LSI0D_POS_PREFETCH_READ_ENABLE         23
`define LSI0D_POS_TA_LO        16
`define LSI0D_POS_BS_LO        4
`define LSI0D_POS_EN           0
`define LSI0D_RESET_BIT        1'b0
`define LSI0D_RESET_TA         16'h0000
`define LSI0D_RESET_BS         4'h0
`define LSI0D_UNMAPPED_DATA    32'h00000000
`endif

// [rtl/lsi0d_top.sv]
// slave image 0 decode: registers over avalon-mm and access classification
// assumes one 100 mhz clock; local bus inputs synchronous to it
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "lsi0d_regs.svh"
module lsi0d_top
    import lsi0d_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // eeprom preload, sampled after reset release
    input  wire logic        eeprom_valid,
    input  wire logic        eeprom_posted_write_enable,
    input  wire logic        eeprom_pci_space_select,
    input  wire logic [15:0] eeprom_translation_address,
    input  wire logic [3:0]  eeprom_block_size_code,
    input  wire logic        eeprom_translation_enable,
    // avalon-mm slave
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // local bus access
    input  wire logic        bridge_chip_select_n,
    input  wire logic        image_select,
    input  wire logic        access_write,
    input  wire logic        access_burst,
    input  wire logic [31:0] access_addr,
    // decoded access to the pci side
    output logic             decode_valid,
    output var lsi0d_action_t decode_action,
    output logic             decode_io_space,
    output logic      [31:0] decode_pci_addr,
    output logic             bus_error
);
    logic        rst_meta_n;
    logic        rst_n;
    logic        preload_done;
    logic        posted_write_enable;
    logic        pci_space_select;
    logic        prefetch_read_enable;
    logic [15:0] translation_address;
    logic [3:0]  block_size_code;
    logic        translation_enable;
    logic        answered;
    logic        hit;
    logic [31:0] xlate_addr;
    lsi0d_action_t next_action;

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // eeprom values caught once, the cycle after release
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            preload_done <= 1'b0;
        end else begin
            preload_done <= 1'b1;
        end
    end

    // bus write strobe: one cycle wait, taken on the answering edge
    wire wr_ctl = avs_write && answered && !preload_done ? 1'b0 :
                  avs_write && answered &&
                  avs_address == `LSI0D_OFS_CONTROL;
    wire wr_xl  = avs_write && answered && preload_done &&
                  avs_address == `LSI0D_OFS_TRANSLATION;

    // control register; prefetch enable never preloaded
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            posted_write_enable  <= `LSI0D_RESET_BIT;
            pci_space_select     <= `LSI0D_RESET_BIT;
            prefetch_read_enable <= `LSI0D_RESET_BIT;
        end else if (!preload_done) begin
            if (eeprom_valid) begin
                posted_write_enable <= eeprom_posted_write_enable;
                pci_space_select    <= eeprom_pci_space_select;
            end
        end else if (wr_ctl) begin
            if (avs_byteenable[3]) begin
                posted_write_enable <= avs_writedata[`LSI0D_POS_POSTED_WRITE_ENABLE];
                pci_space_select    <= avs_writedata[`LSI0D_POS_SPACE];
            end
            if (avs_byteenable[2]) begin
                prefetch_read_enable <= avs_writedata[`LSI0D_POS_PREFETCH_READ_ENABLE];
            end
        end
    end

    // translation register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            translation_address <= `LSI0D_RESET_TA;
            block_size_code     <= `LSI0D_RESET_BS;
            translation_enable  <= `LSI0D_RESET_BIT;
        end else if (!preload_done) begin
            if (eeprom_valid) begin
                translation_address <= eeprom_translation_address;
                block_size_code     <= eeprom_block_size_code;
                translation_enable  <= eeprom_translation_enable;
            end
        end else if (wr_xl) begin
            if (avs_byteenable[3]) begin
                translation_address[15:8] <= avs_writedata[31:24];
            end
            if (avs_byteenable[2]) begin
                translation_address[7:0] <= avs_writedata[23:16];
            end
            if (avs_byteenable[0]) begin
                block_size_code    <=
                    avs_writedata[`LSI0D_POS_BS_LO +: 4];
                translation_enable <= avs_writedata[`LSI0D_POS_EN];
            end
        end
    end

    // every request answered one cycle after it rises
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            answered <= 1'b0;
        end else begin
            answered <= (avs_read || avs_write) && !answered;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !answered;

    // read data registered on the request's first cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !answered) begin
            if (avs_address == `LSI0D_OFS_CONTROL) begin
                avs_readdata <= {posted_write_enable, 6'h00, pci_space_select,
                                 prefetch_read_enable, 23'h000000};
            end else if (avs_address == `LSI0D_OFS_TRANSLATION) begin
                avs_readdata <= {translation_address, 8'h00,
                                 block_size_code, 3'h0,
                                 translation_enable};
            end else begin
                avs_readdata <= `LSI0D_UNMAPPED_DATA;
            end
        end
    end

    // classification of a local access hitting image 0
    assign hit = !bridge_chip_select_n && !image_select;
    always_comb begin
        next_action = LSI0D_NONE;
        if (hit) begin
            if (access_burst && pci_space_select) begin
                next_action = LSI0D_BUS_ERROR;
            end else if (access_write) begin
                if (access_burst) begin
                    next_action = LSI0D_POSTED_WRITE;
                end else if (posted_write_enable && !pci_space_select) begin
                    next_action = LSI0D_POSTED_WRITE;
                end else begin
                    next_action = LSI0D_DELAYED_WRITE;
                end
            end else begin
                if (access_burst) begin
                    next_action = LSI0D_DELAYED_READ;
                end else if (prefetch_read_enable && !pci_space_select) begin
                    next_action = LSI0D_DELAYED_PREFETCH_READ;
                end else begin
                    next_action = LSI0D_DELAYED_READ;
                end
            end
        end
    end

    lsi0d_xlate u_xlate (
        .translation_address (translation_address),
        .block_size_code     (block_size_code),
        .translation_enable  (translation_enable),
        .local_addr          (access_addr),
        .pci_addr            (xlate_addr)
    );

    // decoded outputs registered one cycle after the access
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            decode_valid    <= 1'b0;
            decode_action   <= LSI0D_NONE;
            decode_io_space <= 1'b0;
            decode_pci_addr <= 32'h00000000;
            bus_error       <= 1'b0;
        end else begin
            decode_valid    <= hit;
            decode_action   <= next_action;
            decode_io_space <= hit && pci_space_select;
            decode_pci_addr <= hit ? xlate_addr : 32'h00000000;
            bus_error       <= next_action == LSI0D_BUS_ERROR;
        end
    end
endmodule : lsi0d_top
`default_nettype wire

// [rtl/lsi0d_xlate.sv]
// address translation for slave image 0
// assumes a stable address and settings; purely combinational
`timescale 1ns/10ps
`default_nettype none
module lsi0d_xlate (
    // settings
    input  wire logic [15:0] translation_address,
    input  wire logic [3:0]  block_size_code,
    input  wire logic        translation_enable,
    // addresses
    input  wire logic [31:0] local_addr,
    output logic      [31:0] pci_addr
);
    logic [15:0] sel_mask;
    // one bit per upper line; line 16+i is translated when i >= code
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_mask
            assign sel_mask[i] = translation_enable &&
                                 (4'(i) >= block_size_code);
        end
    endgenerate
    assign pci_addr[15:0]  = local_addr[15:0];
    assign pci_addr[31:16] = (translation_address & sel_mask) |
                             (local_addr[31:16] & ~sel_mask);
endmodule : lsi0d_xlate
`default_nettype wire
